// File: shared/counter_pkg.sv
`default_nettype none
package counter_pkg;
    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [7:0] FLAG_INDEX = 8'h0C;
    localparam logic [7:0] LOW_INDEX = 8'h0E;
    localparam logic [7:0] HIGH_INDEX = 8'h0F;
    localparam logic [7:0] CONTROL_INDEX = 8'h10;
    localparam logic [7:0] COMPARE_INDEX = 8'h14;
    localparam logic [7:0] COMPARE_MODE_INDEX = 8'h15;
    localparam int ADDR_SHIFT = 2;

    // ****************************************
    // Control and flag register fields
    // ****************************************
    localparam int CTRL_ON_POS = 0;
    localparam int CTRL_EXT_POS = 1;
    localparam int CTRL_BYPASS_POS = 2;
    localparam int CTRL_OSC_POS = 3;
    localparam int CTRL_PS_POS = 4;
    localparam int FLAG_OVF_POS = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ****************************************
    // Compare and bus codes
    // ****************************************
    localparam logic [3:0] MODE_SPECIAL_EVENT = 4'hB;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : counter_pkg
`default_nettype wire

// File: core/timer_counter.sv
// How it works
// [RULE_01] External select counts rising edges of crystal input if oscillator on, else count pin.
// [RULE_02] Bypass clear: prescaler output passes one synchroniser stage before counting.
// [RULE_03] Prescaler advances directly on each selected external edge.
// [RULE_04] Synchronised counter mode in sleep: count holds, prescaler still advances.
// [RULE_05] Bypass set, bit 2: count increments straight from prescaler output.
// [RULE_06] Asynchronous mode keeps counting in sleep; overflow flag can wake processor.
// [RULE_07] No capture/compare time base offered in asynchronous mode.
// [RULE_08] Count byte reads return stable registered values.
// [RULE_09] Software should stop counter before writing count bytes.
// [RULE_10] Software reads high, low, high again; repeats if highs differ.
// [RULE_11] Software clears low byte, writes high, then low, interrupts off.
// [RULE_12] Oscillator enable, bit 3, drives crystal amplifier between crystal pins.
// [RULE_13] Oscillator keeps running in every power-managed mode.
// [RULE_14] Software waits its own delay after enabling oscillator.
// [RULE_15] Compare mode 1011 match resets count and starts a conversion.
// [RULE_16] Trigger reset never sets the overflow flag, bit 0.
// [RULE_17] Trigger reset acts only in timer or synchronised counter mode.
// [RULE_18] Count write in trigger cycle wins over the reset.
// [RULE_19] Compare pair acts as the counter period under trigger.
// [RULE_20] Count wraps FFFFh to 0000h and latches the overflow flag.
// [RULE_21] Prescale select 00..11 divides by 1, 2, 4, 8.
// [RULE_22] After enable in counter mode, a falling edge must precede counting.
// [RULE_23] Timer mode counts every instruction clock and ignores bypass bit.
// [RULE_24] Counter off holds count and prescaler, ignoring all edges.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module timer_counter
    import counter_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic extCountPin,
    input wire logic crystalInPin,
    output logic crystalOutPin,
    output logic crystalOutOe,
    input wire logic sleepMode,
    output logic overflowFlag,
    output logic adcStart,
    output logic [15:0] timeBase,
    output logic timeBaseValid
);
    typedef struct packed {
        logic [15:0] count;
        logic [2:0] prescale;
        logic armed;
        logic inPrev;
        logic syncPulse;
        logic flag;
        logic [7:0] control;
        logic [15:0] compare;
        logic [3:0] compareMode;
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic adcStart;
        logic oscOut;
        logic timeBaseValid;
        logic [15:0] timeBase;
    } state_t;

    localparam state_t STATE_RESET = '{awReady: 1'b1, wReady: 1'b1, arReady: 1'b1,
        control: CONTROL_RESET, default: '0};

    state_t s;
    state_t next_s;

    logic ctrlOn;
    logic ctrlExt;
    logic ctrlBypass;
    logic ctrlOsc;
    logic [1:0] ctrlPs;
    logic selIn;
    logic prescaleTick;
    logic [2:0] psMask;
    logic prescaleOut;
    logic asyncMode;
    logic incEvent;
    logic trig;
    logic busWrite;
    logic countWrite;
    logic [7:0] wIndex;
    logic [7:0] rIndex;
    logic [16:0] countPlus;

    assign ctrlOn = s.control[CTRL_ON_POS];
    assign ctrlExt = s.control[CTRL_EXT_POS];
    assign ctrlBypass = s.control[CTRL_BYPASS_POS];
    assign ctrlOsc = s.control[CTRL_OSC_POS];
    assign ctrlPs = s.control[CTRL_PS_POS +: 2];
    assign asyncMode = ctrlExt && ctrlBypass;
    assign selIn = ctrlOsc ? crystalInPin : extCountPin; // [RULE_01]
    assign psMask = 3'((4'h1 << ctrlPs) - 4'h1);
    assign busWrite = s.awHeld && s.wHeld && !s.bValid;
    assign countWrite = busWrite && (wIndex == LOW_INDEX || wIndex == HIGH_INDEX) && s.wStrb[0];
    assign wIndex = 8'(s.awAddr >> ADDR_SHIFT);
    assign rIndex = 8'(s_axi_araddr >> ADDR_SHIFT);
    assign countPlus = {1'b0, s.count} + 17'h00001;

    // ****************************************
    // Count path
    // ****************************************
    always_comb begin
        next_s = s;
        next_s.adcStart = 1'b0;
        next_s.inPrev = selIn;
        next_s.oscOut = !crystalInPin; // [RULE_12] [RULE_13]
        // Edge source: external rising edge after arming, else every cycle
        prescaleTick = 1'b0;
        if (ctrlOn) begin
            if (ctrlExt) begin
                prescaleTick = s.armed && selIn && !s.inPrev; // [RULE_01] [RULE_22]
            end else begin
                prescaleTick = 1'b1; // [RULE_23]
            end
        end
        if (!ctrlOn) begin
            next_s.armed = 1'b0; // [RULE_22]
        end else if (s.inPrev && !selIn) begin
            next_s.armed = 1'b1; // [RULE_22]
        end
        prescaleOut = prescaleTick && ((s.prescale & psMask) == psMask); // [RULE_21]
        if (prescaleTick) begin
            next_s.prescale = s.prescale + 3'h1; // [RULE_03] [RULE_04]
        end
        next_s.syncPulse = prescaleOut && ctrlExt && !ctrlBypass && !sleepMode; // [RULE_02] [RULE_04]
        if (!ctrlOn) begin
            incEvent = 1'b0; // [RULE_24]
        end else if (!ctrlExt) begin
            incEvent = prescaleOut && !sleepMode; // [RULE_23]
        end else if (ctrlBypass) begin
            incEvent = prescaleOut; // [RULE_05] [RULE_06]
        end else begin
            incEvent = s.syncPulse; // [RULE_02]
        end
        trig = ctrlOn && !asyncMode && s.compareMode == MODE_SPECIAL_EVENT
            && s.count == s.compare; // [RULE_15] [RULE_17] [RULE_19]
        if (trig) begin
            next_s.count = countWrite ? s.count : 16'h0000; // [RULE_15] [RULE_16] [RULE_18]
            next_s.adcStart = 1'b1; // [RULE_15]
        end else if (incEvent) begin
            next_s.count = countPlus[15:0]; // [RULE_20]
        end
        next_s.timeBaseValid = !asyncMode; // [RULE_07]
        next_s.timeBase = asyncMode ? 16'h0000 : s.count; // [RULE_07]

        // ****************************************
        // Register writes
        // ****************************************
        if (busWrite) begin
            next_s.bValid = 1'b1;
            next_s.bResp = RESP_OKAY;
            next_s.awHeld = 1'b0;
            next_s.wHeld = 1'b0;
            case (wIndex)
                LOW_INDEX: begin
                    if (s.wStrb[0]) begin
                        next_s.count[7:0] = s.wData[7:0]; // [RULE_18] [RULE_09]
                        next_s.prescale = 3'h0;
                    end
                end
                HIGH_INDEX: begin
                    if (s.wStrb[0]) begin
                        next_s.count[15:8] = s.wData[7:0]; // [RULE_18] [RULE_11]
                        next_s.prescale = 3'h0;
                    end
                end
                CONTROL_INDEX: begin
                    if (s.wStrb[0]) begin
                        next_s.control = {2'b00, s.wData[5:0]};
                    end
                end
                FLAG_INDEX: begin
                    if (s.wStrb[0] && !s.wData[FLAG_OVF_POS]) begin
                        next_s.flag = 1'b0;
                    end
                end
                COMPARE_INDEX: begin
                    if (s.wStrb[0]) begin
                        next_s.compare[7:0] = s.wData[7:0];
                    end
                    if (s.wStrb[1]) begin
                        next_s.compare[15:8] = s.wData[15:8];
                    end
                end
                COMPARE_MODE_INDEX: begin
                    if (s.wStrb[0]) begin
                        next_s.compareMode = s.wData[3:0];
                    end
                end
                default: begin
                    next_s.bResp = RESP_SLVERR;
                end
            endcase
        end
        // Overflow set wins over a clear in the same cycle
        if (incEvent && !trig && countPlus[16] && !countWrite) begin
            next_s.flag = 1'b1; // [RULE_20] [RULE_06] [RULE_16]
        end

        // ****************************************
        // Bus handshakes
        // ****************************************
        if (s_axi_awvalid && s.awReady) begin
            next_s.awHeld = 1'b1;
            next_s.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wReady) begin
            next_s.wHeld = 1'b1;
            next_s.wData = s_axi_wdata;
            next_s.wStrb = s_axi_wstrb;
        end
        if (s.bValid && s_axi_bready) begin
            next_s.bValid = 1'b0;
        end
        next_s.awReady = !next_s.awHeld && !next_s.bValid;
        next_s.wReady = !next_s.wHeld && !next_s.bValid;
        if (s_axi_arvalid && s.arReady) begin
            next_s.rValid = 1'b1;
            next_s.arReady = 1'b0;
            next_s.rResp = RESP_OKAY;
            case (rIndex)
                LOW_INDEX: next_s.rData = {24'h000000, s.count[7:0]}; // [RULE_08]
                HIGH_INDEX: next_s.rData = {24'h000000, s.count[15:8]}; // [RULE_08]
                CONTROL_INDEX: next_s.rData = {24'h000000, s.control};
                FLAG_INDEX: next_s.rData = {31'h00000000, s.flag};
                COMPARE_INDEX: next_s.rData = {16'h0000, s.compare};
                COMPARE_MODE_INDEX: next_s.rData = {28'h0000000, s.compareMode};
                default: begin
                    next_s.rData = 32'h00000000;
                    next_s.rResp = RESP_SLVERR;
                end
            endcase
        end else if (s.rValid && s_axi_rready) begin
            next_s.rValid = 1'b0;
            next_s.arReady = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awReady;
    assign s_axi_wready = s.wReady;
    assign s_axi_bvalid = s.bValid;
    assign s_axi_bresp = s.bResp;
    assign s_axi_arready = s.arReady;
    assign s_axi_rvalid = s.rValid;
    assign s_axi_rdata = s.rData;
    assign s_axi_rresp = s.rResp;
    assign crystalOutPin = s.oscOut;
    assign crystalOutOe = ctrlOsc;
    assign overflowFlag = s.flag;
    assign adcStart = s.adcStart;
    assign timeBase = s.timeBase;
    assign timeBaseValid = s.timeBaseValid;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_off_holds: assert property (!ctrlOn && !busWrite |=> $stable(s.count)
        && $stable(s.prescale)) else $error("count moved while off"); // [RULE_24]
    a_trig_clears: assert property (trig && !busWrite |=> s.count == 16'h0000
        && s.adcStart) else $error("trigger did not clear count"); // [RULE_15]
    a_trig_no_flag: assert property (trig && !s.flag && !busWrite |=> !s.flag)
        else $error("trigger set overflow flag"); // [RULE_16]
    a_write_wins: assert property (trig && busWrite && wIndex == LOW_INDEX && s.wStrb[0]
        |=> s.count == {$past(s.count[15:8]), $past(s.wData[7:0])})
        else $error("trigger beat write"); // [RULE_18]
    a_wrap_flag: assert property (incEvent && s.count == COUNT_MAX && !trig && !busWrite
        |=> s.flag && s.count == 16'h0000) else $error("rollover lost"); // [RULE_20]
    a_async_no_trig: assert property (asyncMode |-> !trig)
        else $error("trigger in asynchronous mode"); // [RULE_17]
    a_async_no_base: assert property (asyncMode && !busWrite |=> !timeBaseValid)
        else $error("time base offered asynchronously"); // [RULE_07]
    a_sync_sleep: assert property (ctrlExt && !ctrlBypass && sleepMode && !busWrite
        ##1 !trig && !busWrite |=> $stable(s.count)) else $error("counted in sleep"); // [RULE_04]
    a_timer_rate: assert property (ctrlOn && !ctrlExt && ctrlPs == 2'b00 && !sleepMode
        && !trig && !busWrite |=> s.count == $past(s.count) + 16'h0001)
        else $error("timer missed a cycle"); // [RULE_23]
    a_need_falling: assert property (ctrlOn && ctrlExt && !s.armed |-> !prescaleTick)
        else $error("counted before falling edge"); // [RULE_22]
    a_async_direct: assert property (ctrlOn && asyncMode && prescaleOut && !trig
        && !busWrite |=> s.count != $past(s.count)) else $error("async edge lost"); // [RULE_05]
    a_div_eight: assert property (ctrlPs == 2'b11 && prescaleOut |-> s.prescale == 3'h7)
        else $error("prescale ratio wrong"); // [RULE_21]

    c_wrap: cover property (incEvent && s.count == COUNT_MAX);
    c_trigger: cover property (trig);
    c_async_sleep: cover property (asyncMode && sleepMode && incEvent);
    c_read_done: cover property (s.rValid && s_axi_rready);
    c_write_trig: cover property (trig && countWrite);
endmodule : timer_counter
`default_nettype wire

// File: testbench/edge_source.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// External count pin and watch crystal
// ****************************************
module edge_source (
    input wire logic ref_clk,
    output logic extCountPin,
    output logic crystalInPin
);
    initial begin
        extCountPin = 1'b0;
        crystalInPin = 1'b0;
    end

    // Pulses on one line only; the other stands still
    task automatic pulses(input bit onCrystal, input int n, input int hold);
        repeat (n) begin
            @(posedge ref_clk);
            if (onCrystal) crystalInPin <= 1'b1;
            else extCountPin <= 1'b1;
            repeat (hold) @(posedge ref_clk);
            crystalInPin <= 1'b0;
            extCountPin <= 1'b0;
            repeat (hold - 1) @(posedge ref_clk);
        end
    endtask : pulses
endmodule : edge_source
`default_nettype wire

// File: testbench/timer1_counter_modes_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module timer1_counter_modes_tb;
    import counter_pkg::*;
    localparam logic [31:0] ON = 32'h1 << CTRL_ON_POS;
    localparam logic [31:0] EXT = 32'h1 << CTRL_EXT_POS;
    localparam logic [31:0] BYP = 32'h1 << CTRL_BYPASS_POS;
    localparam logic [31:0] OSC = 32'h1 << CTRL_OSC_POS;
    logic ref_clk = 1'b0, reset_n = 1'b0, sleepMode = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic extCountPin, crystalInPin, crystalOutOe, overflowFlag, adcStart, timeBaseValid;
    logic crystalOutPin;
    logic [31:0] rd;
    logic [15:0] cnt, timeBase;
    int fails = 0, totalChecks = 0, adcCount = 0, a0;

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (adcStart === 1'b1) adcCount++;

    edge_source src (.ref_clk(ref_clk), .extCountPin(extCountPin),
        .crystalInPin(crystalInPin));
    timer_counter #(.ADDR_W(8)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .extCountPin(extCountPin), .crystalInPin(crystalInPin),
        .crystalOutPin(crystalOutPin), .crystalOutOe(crystalOutOe), .sleepMode(sleepMode),
        .overflowFlag(overflowFlag), .adcStart(adcStart), .timeBase(timeBase),
        .timeBaseValid(timeBaseValid));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic axi_write(input logic [7:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= idx << ADDR_SHIFT;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] idx);
        @(posedge ref_clk);
        s_axi_araddr <= idx << ADDR_SHIFT;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // High, low, high again; retry on a carry between
    task automatic read_count();
        logic [7:0] h;
        axi_read(HIGH_INDEX);
        h = rd[7:0];
        axi_read(LOW_INDEX);
        cnt = {h, rd[7:0]};
        axi_read(HIGH_INDEX);
        if (rd[7:0] !== h) begin
            axi_read(HIGH_INDEX);
            h = rd[7:0];
            axi_read(LOW_INDEX);
            cnt = {h, rd[7:0]};
        end
    endtask : read_count

    // Stop, clear low, then high, then low
    task automatic load_count(input logic [15:0] v);
        axi_write(CONTROL_INDEX, 32'h0);
        axi_write(LOW_INDEX, 32'h0);
        axi_write(HIGH_INDEX, {24'h0, v[15:8]});
        axi_write(LOW_INDEX, {24'h0, v[7:0]});
    endtask : load_count

    task automatic ext_case(input logic [31:0] c, input bit xtal, input int n,
        input logic [15:0] start, input logic [15:0] exp);
        load_count(start);
        axi_write(CONTROL_INDEX, c);
        repeat (4) @(posedge ref_clk);
        src.pulses(xtal, n, 2 + n % 2);
        repeat (6) @(posedge ref_clk);
        read_count();
        `CHECK("count", exp, cnt)
    endtask : ext_case

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        axi_read(CONTROL_INDEX);
        `CHECK("control reset", {24'h0, CONTROL_RESET}, rd)
        axi_read(8'h01);
        `CHECK("unmapped rresp", RESP_SLVERR, resp)
        axi_write(8'h02, 32'h5A);
        `CHECK("unmapped bresp", RESP_SLVERR, resp)
        for (int ps = 0; ps < 4; ps++) begin
            ext_case(ON | EXT | (ps << CTRL_PS_POS), 1'b0, 9, 16'h0, 16'(8 >> ps));
        end
        ext_case(ON | EXT | OSC, 1'b1, 5, 16'h0, 16'h0004);
        sleepMode <= 1'b1;
        ext_case(ON | EXT, 1'b0, 5, 16'h0033, 16'h0033);
        ext_case(ON | EXT | BYP | OSC, 1'b1, 5, 16'h0, 16'h0004);
        `CHECK("osc enable", 1'b1, crystalOutOe)
        ext_case(ON | EXT | BYP, 1'b0, 4, 16'hFFFE, 16'h0001);
        axi_read(FLAG_INDEX);
        `CHECK("flag wrap", 1'b1, rd[FLAG_OVF_POS])
        `CHECK("wake flag", 1'b1, overflowFlag)
        axi_write(CONTROL_INDEX, ON | EXT | BYP);
        repeat (2) @(posedge ref_clk);
        `CHECK("async base", 1'b0, timeBaseValid)
        sleepMode <= 1'b0;
        ext_case(32'h0, 1'b0, 4, 16'h0001, 16'h0001);
        axi_write(FLAG_INDEX, 32'h0);
        axi_write(COMPARE_INDEX, 32'h0010);
        axi_write(COMPARE_MODE_INDEX, {28'h0, MODE_SPECIAL_EVENT});
        load_count(16'h0);
        a0 = adcCount;
        axi_write(CONTROL_INDEX, ON | BYP);
        repeat (100) @(posedge ref_clk);
        `CHECK("trigger pulses", 1'b1, (adcCount - a0) >= 5)
        `CHECK("sync base", 1'b1, timeBaseValid)
        axi_write(CONTROL_INDEX, 32'h0);
        read_count();
        `CHECK("period bound", 1'b1, cnt <= 16'h0010)
        axi_read(FLAG_INDEX);
        `CHECK("flag trigger", 1'b0, rd[FLAG_OVF_POS])
        // Timer held by sleep at the compare value, so the trigger fires every cycle
        load_count(16'h0);
        axi_write(COMPARE_INDEX, 32'h0);
        sleepMode <= 1'b1;
        axi_write(CONTROL_INDEX, ON);
        axi_write(LOW_INDEX, 32'h37);
        axi_write(CONTROL_INDEX, 32'h0);
        read_count();
        `CHECK("write over trigger", 16'h0037, cnt)
        `CHECK("time base copy", 16'h0037, timeBase)
        `CHECK("crystal out", 1'b1, crystalOutPin)
        report_and_stop();
    end
endmodule : timer1_counter_modes_tb
`default_nettype wire
